/* File: include/pst_defines.vh */
// register map, field layout and reset values of the processor-state block
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PST_OFF_STATE   5'h00
`define PST_OFF_TL      5'h04
`define PST_OFF_PIL     5'h08
`define PST_OFF_FPRS    5'h0c
`define PST_OFF_WPLO    5'h10
`define PST_OFF_WPHI    5'h14
`define PST_OFF_STAT    5'h18

// ----------------------------------------------------------------------
// processor-state word fields
// ----------------------------------------------------------------------
`define PST_MM_LO       0
`define PST_MM_HI       1
`define PST_PEF         2
`define PST_AM          3
`define PST_PRIV        4
`define PST_IE          5
`define PST_AG          6
`define PST_STATE_W     6

// ----------------------------------------------------------------------
// memory model encodings
// ----------------------------------------------------------------------
`define PST_MM_TSO      2'h0
`define PST_MM_RSVD     2'h1
`define PST_MM_RMO      2'h2
`define PST_MM_IMP      2'h3

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define PST_TL_W        3
`define PST_PIL_W       4
`define PST_MAX_TL      3'h2
`define PST_STATE_RST   6'h10
`define PST_TL_RST      3'h0
`define PST_PIL_RST     4'h0
`define PST_FEF_RST     1'b0

`endif

/* File: src/pst_mask64.v */
// registered 64-bit address holder with optional upper-half masking
`timescale 1ns/1ps
`default_nettype none

module pst_mask64 (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        load,
    input  wire        mask,
    input  wire [63:0] addr_in,
    output reg  [63:0] addr_r
);

    // ------------------------------------------------------------------
    // capture, zeroing bits 63:32 when asked
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            addr_r <= 64'h0;
        end else if (load) begin
            addr_r <= mask ? {32'h0, addr_in[31:0]} : addr_in;
        end
    end

endmodule
`default_nettype wire

/* File: src/pst_core.v */
// processor-state, trap-level and interrupt-level control with Avalon slave
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pst_defines.vh"

module pst_core #(
    parameter HAS_FPU    = 1,
    parameter HAS_RMO    = 1,
    parameter RET_MASK   = 0,
    parameter [2:0] MAX_TL = `PST_MAX_TL
) (
    input  wire        clk,
    input  wire        rst_n,
    // avalon-mm slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // memory system side
    input  wire        mmu_en,
    input  wire        data_req,
    input  wire [63:0] data_va,
    input  wire        data_real,
    input  wire        data_nontrans,
    output wire [63:0] data_addr_r,
    output reg         data_valid_r,
    output reg  [1:0]  memory_model_field_r,
    output reg         order_ld_ld_r,
    output reg         order_ld_st_r,
    output reg         order_st_st_r,
    output reg         total_store_order_r,
    output reg         relaxed_order_model_r,
    // program counter flow
    input  wire        insn_step,
    input  wire        cti_taken,
    input  wire [63:0] cti_target,
    input  wire        inst_real,
    output reg  [63:0] next_program_counter_r,
    output wire [63:0] fetch_addr_r,
    input  wire        link_save,
    input  wire [63:0] cur_pc,
    output wire [63:0] link_pc_r,
    // trap entry, return and saved pc access
    input  wire        trap_entry,
    input  wire        trap_return,
    input  wire [5:0]  ret_state,
    input  wire [63:0] ret_pc,
    output wire [63:0] ret_pc_r,
    output reg         ret_valid_r,
    input  wire        tpc_wr,
    input  wire        saved_trap_next_pc_wr,
    input  wire [63:0] tpc_wr_data,
    output wire [63:0] saved_trap_pc_r,
    output wire [63:0] saved_trap_next_pc_r,
    // floating point gating
    input  wire        fp_insn,
    output reg         fp_go_r,
    output reg         fpu_off_trap_r,
    // watchpoint
    output reg         wp_hit_r,
    // privilege and interrupts
    input  wire [15:1] irq_level_req,
    output reg         priv_mode_r,
    output reg         irq_take_r,
    output reg  [3:0]  irq_level_r,
    output reg  [2:0]  trap_level_r
);

    // ------------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------------
    reg  [1:0]  mm_r;
    reg         pef_r;
    reg         am_r;
    reg         priv_r;
    reg         ie_r;
    reg         fef_r;
    reg  [3:0]  pil_r;
    reg  [63:0] wp_r;
    reg  [2:0]  tl_nxt;
    reg  [31:0] rd_nxt;
    reg  [3:0]  top_lvl;
    reg  [63:0] npc_nxt;
    integer     i, j;
    localparam [5:0] ST_RST = `PST_STATE_RST;

    wire        bus_req   = avs_read | avs_write;
    wire        wr_go     = avs_write & ~avs_waitrequest;
    wire        lane0     = avs_byteenable[0];
    wire        st_wr     = wr_go & lane0 & (avs_address == `PST_OFF_STATE);
    wire        mask_on   = am_r & mmu_en;
    wire        fp_ok     = pef_r & fef_r;
    wire        ret_am    = ret_state[`PST_AM];
    wire        ret_msk   = (RET_MASK != 0) & ret_am;

    // masked data address, also the watchpoint comparator input
    wire        data_msk  = mask_on & ~data_real & ~data_nontrans;
    wire [63:0] wp_cmp_va = data_msk ? {32'h0, data_va[31:0]} : data_va;

    // state word as software sees it; alternate-globals bit stays zero
    wire [5:0]  state_rd  = {ie_r, priv_r, am_r,
                             (HAS_FPU != 0) & pef_r, mm_r};

    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, then the transfer completes
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
        end
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        rd_nxt = 32'h0;
        case (avs_address)
            `PST_OFF_STATE: rd_nxt = {26'h0, state_rd};
            `PST_OFF_TL:    rd_nxt = {29'h0, trap_level_r};
            `PST_OFF_PIL:   rd_nxt = {28'h0, pil_r};
            `PST_OFF_FPRS:  rd_nxt = {31'h0, fef_r};
            `PST_OFF_WPLO:  rd_nxt = wp_r[31:0];
            `PST_OFF_WPHI:  rd_nxt = wp_r[63:32];
            `PST_OFF_STAT:  rd_nxt = {26'h0, fp_ok,
                                      (trap_level_r != 3'h0), top_lvl};
            default:        rd_nxt = 32'h0;
        endcase
    end

    // read data loaded one edge ahead so it stands while waitrequest is low
    always @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= rd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // processor-state word: bus writes and trap return restore
    // ------------------------------------------------------------------
    // written bits are visible to the very next instruction
    always @(posedge clk) begin
        if (!rst_n) begin
            mm_r   <= ST_RST[`PST_MM_HI:`PST_MM_LO];
            pef_r  <= ST_RST[`PST_PEF];
            am_r   <= ST_RST[`PST_AM];
            priv_r <= ST_RST[`PST_PRIV];
            ie_r   <= ST_RST[`PST_IE];
        end else if (trap_return) begin
            mm_r   <= ret_state[`PST_MM_HI:`PST_MM_LO];
            pef_r  <= ret_state[`PST_PEF] & (HAS_FPU != 0);
            am_r   <= ret_am;
            priv_r <= ret_state[`PST_PRIV];
            ie_r   <= ret_state[`PST_IE];
        end else if (st_wr) begin
            mm_r   <= avs_writedata[`PST_MM_HI:`PST_MM_LO];
            pef_r  <= avs_writedata[`PST_PEF] & (HAS_FPU != 0);
            am_r   <= avs_writedata[`PST_AM];
            priv_r <= avs_writedata[`PST_PRIV];
            ie_r   <= avs_writedata[`PST_IE];
        end
    end

    // ------------------------------------------------------------------
    // other software registers: fp status enable, threshold, watchpoint
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            fef_r <= `PST_FEF_RST;
            pil_r <= `PST_PIL_RST;
            wp_r  <= 64'h0;
        end else if (wr_go) begin
            if (lane0 && avs_address == `PST_OFF_FPRS) begin
                fef_r <= avs_writedata[0];
            end
            if (lane0 && avs_address == `PST_OFF_PIL) begin
                pil_r <= avs_writedata[3:0];
            end
            // watchpoint honours every byte lane
            for (i = 0; i < 4; i = i + 1) begin
                if (avs_byteenable[i] && avs_address == `PST_OFF_WPLO) begin
                    wp_r[i*8 +: 8] <= avs_writedata[i*8 +: 8];
                end
                if (avs_byteenable[i] && avs_address == `PST_OFF_WPHI) begin
                    wp_r[32 + i*8 +: 8] <= avs_writedata[i*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // trap level: entry, return, direct write
    // ------------------------------------------------------------------
    // a direct write touches only the level itself, never pc or state
    always @* begin
        tl_nxt = trap_level_r;
        if (wr_go && lane0 && avs_address == `PST_OFF_TL) begin
            if (avs_writedata[31:3] != 29'h0 ||
                avs_writedata[2:0] > MAX_TL) begin
                tl_nxt = MAX_TL;
            end else begin
                tl_nxt = avs_writedata[2:0];
            end
        end else if (trap_entry && trap_level_r < MAX_TL) begin
            tl_nxt = trap_level_r + 3'h1;
        end else if (trap_return && trap_level_r != 3'h0) begin
            tl_nxt = trap_level_r - 3'h1;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            trap_level_r <= `PST_TL_RST;
        end else begin
            trap_level_r <= tl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // memory ordering from the model field
    // ------------------------------------------------------------------
    // reserved and unsupported codes fall back to store order: stronger
    // ordering still runs any software correctly, only slower
    always @(posedge clk) begin
        if (!rst_n) begin
            memory_model_field_r  <= `PST_MM_TSO;
            total_store_order_r   <= 1'b1;
            relaxed_order_model_r <= 1'b0;
            order_ld_ld_r         <= 1'b1;
            order_ld_st_r         <= 1'b1;
            order_st_st_r         <= 1'b1;
        end else begin
            memory_model_field_r <= mm_r;
            if (mm_r == `PST_MM_RMO && HAS_RMO != 0) begin
                total_store_order_r   <= 1'b0;
                relaxed_order_model_r <= 1'b1;
                order_ld_ld_r         <= 1'b0;
                order_ld_st_r         <= 1'b0;
                order_st_st_r         <= 1'b0;
            end else begin
                total_store_order_r   <= 1'b1;
                relaxed_order_model_r <= 1'b0;
                order_ld_ld_r         <= 1'b1;
                order_ld_st_r         <= 1'b1;
                order_st_st_r         <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // floating point gate and disabled trap
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            fp_go_r        <= 1'b0;
            fpu_off_trap_r <= 1'b0;
        end else begin
            fp_go_r        <= fp_insn & fp_ok;
            fpu_off_trap_r <= fp_insn & ~fp_ok;
        end
    end

    // ------------------------------------------------------------------
    // next-pc sequencing: branch targets and increments keep all 64 bits
    // ------------------------------------------------------------------
    always @* begin
        npc_nxt = next_program_counter_r;
        if (trap_return) begin
            npc_nxt = ret_msk ? {32'h0, ret_pc[31:0]} : ret_pc;
        end else if (insn_step) begin
            npc_nxt = cti_taken ? cti_target
                                : next_program_counter_r + 64'h4;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            next_program_counter_r <= 64'h0;
        end else begin
            next_program_counter_r <= npc_nxt;
        end
    end

    // ------------------------------------------------------------------
    // address holders
    // ------------------------------------------------------------------
    // data address leaving the core
    pst_mask64 u_data (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (data_req),
        .mask    (data_msk),
        .addr_in (data_va),
        .addr_r  (data_addr_r)
    );

    // fetch uses the current mask bit, so a turn-on truncates at once
    pst_mask64 u_fetch (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (1'b1),
        .mask    (am_r & mmu_en & ~inst_real),
        .addr_in (npc_nxt),
        .addr_r  (fetch_addr_r)
    );

    // pc saved by call, jump_and_link or read_pc_insn
    pst_mask64 u_link (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (link_save),
        .mask    (mask_on),
        .addr_in (cur_pc),
        .addr_r  (link_pc_r)
    );

    // pc loaded by trap return
    pst_mask64 u_ret (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (trap_return),
        .mask    (ret_msk),
        .addr_in (ret_pc),
        .addr_r  (ret_pc_r)
    );

    // saved trap pc: masked at entry, kept whole on privileged write
    pst_mask64 u_tpc (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (trap_entry | tpc_wr),
        .mask    (trap_entry & mask_on),
        .addr_in (trap_entry ? cur_pc : tpc_wr_data),
        .addr_r  (saved_trap_pc_r)
    );

    // saved trap next-pc, same treatment
    pst_mask64 u_saved_trap_next_pc (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (trap_entry | saved_trap_next_pc_wr),
        .mask    (trap_entry & mask_on),
        .addr_in (trap_entry ? next_program_counter_r : tpc_wr_data),
        .addr_r  (saved_trap_next_pc_r)
    );

    always @(posedge clk) begin
        if (!rst_n) begin
            data_valid_r <= 1'b0;
            ret_valid_r  <= 1'b0;
        end else begin
            data_valid_r <= data_req;
            ret_valid_r  <= trap_return;
        end
    end

    // ------------------------------------------------------------------
    // watchpoint: full-width compare against the masked address
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            wp_hit_r <= 1'b0;
        end else begin
            wp_hit_r <= data_req & ~data_real & (wp_cmp_va == wp_r);
        end
    end

    // ------------------------------------------------------------------
    // leveled interrupts: highest pending level, all levels maskable
    // ------------------------------------------------------------------
    always @* begin
        top_lvl = 4'h0;
        for (j = 1; j < 16; j = j + 1) begin
            if (irq_level_req[j]) begin
                top_lvl = j[3:0];
            end
        end
    end

    // held pending while enable is clear or level not above threshold
    always @(posedge clk) begin
        if (!rst_n) begin
            irq_take_r  <= 1'b0;
            irq_level_r <= 4'h0;
            priv_mode_r <= 1'b1;
        end else begin
            irq_take_r  <= ie_r & (top_lvl > pil_r);
            irq_level_r <= top_lvl;
            priv_mode_r <= priv_r;
        end
    end

endmodule
`default_nettype wire

/* File: verif/pst_core_asserts.sv */
// concurrent checks on the processor-state block ports
`timescale 1ns/1ps
`default_nettype none
module pst_core_asserts #(
    parameter [2:0] MAX_TL = 3'h2
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [4:0]  avs_address,
    input wire logic        fp_insn,
    input wire logic        fp_go_r,
    input wire logic        fpu_off_trap_r,
    input wire logic        data_req,
    input wire logic        mmu_en,
    input wire logic        data_real,
    input wire logic        data_nontrans,
    input wire logic [63:0] data_va,
    input wire logic [63:0] data_addr_r,
    input wire logic        data_valid_r,
    input wire logic        insn_step,
    input wire logic        cti_taken,
    input wire logic [63:0] cti_target,
    input wire logic        trap_return,
    input wire logic [63:0] next_program_counter_r,
    input wire logic        trap_entry,
    input wire logic [2:0]  trap_level_r,
    input wire logic [15:1] irq_level_req,
    input wire logic        irq_take_r
);
    // ------
    // clocking and helpers
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus write of trap level outranks a trap entry in the same cycle
    logic tl_wr;
    assign tl_wr = avs_write && !avs_waitrequest && avs_address == 5'h04;
    // ------
    // properties
    // ------
    AST_ONE_WAIT: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait state");
    AST_FP_PAIR: assert property (
        fp_insn |=> fp_go_r != fpu_off_trap_r)
        else $error("fpu gate outputs not exclusive");
    AST_DATA_FULL: assert property (
        data_req && (!mmu_en || data_real || data_nontrans)
        |=> data_valid_r && data_addr_r == $past(data_va))
        else $error("unmaskable data address altered");
    AST_NPC_INC: assert property (
        insn_step && !cti_taken && !trap_return
        |=> next_program_counter_r == $past(next_program_counter_r) + 64'h4)
        else $error("next pc not advanced by four");
    AST_NPC_CTI: assert property (
        insn_step && cti_taken && !trap_return
        |=> next_program_counter_r == $past(cti_target))
        else $error("branch target not kept whole");
    AST_TL_MAX: assert property (
        trap_level_r <= MAX_TL)
        else $error("trap level above maximum");
    AST_TL_ENTRY: assert property (
        trap_entry && !tl_wr |=> trap_level_r == ($past(trap_level_r) < MAX_TL
        ? $past(trap_level_r) + 3'h1 : MAX_TL))
        else $error("trap entry did not raise trap level");
    AST_IRQ_IDLE: assert property (
        irq_level_req == 15'h0 |=> !irq_take_r)
        else $error("interrupt taken with nothing pending");
endmodule
bind pst_core pst_core_asserts #(.MAX_TL(MAX_TL)) u_chk (.*);
`default_nettype wire

/* File: verif/pst_irq_src.sv */
// interrupt source bank: a level stays pending until taken or cleared
`timescale 1ns/1ps
`default_nettype none
module pst_irq_src (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:1] raise,
    input  wire logic        clr,
    input  wire logic        take,
    input  wire logic [3:0]  lvl,
    output var  logic [15:1] irq_level_req
);
    // ------
    // pending latch
    // ------
    // a masked level must not be lost, so sources hold until served
    logic [15:1] served;
    assign served = take ? (15'h1 << (lvl - 4'h1)) : 15'h0;
    always @(posedge clk) begin
        if (!rst_n || clr)
            irq_level_req <= 15'h0;
        else
            irq_level_req <= (irq_level_req | raise) & ~served;
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the processor-state block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, mmu_en;
    logic        data_req, data_real, data_nontrans, data_valid_r, clr, msk;
    logic        insn_step, cti_taken, inst_real, link_save, trap_entry;
    logic        trap_return, ret_valid_r, tpc_wr, saved_trap_next_pc_wr, fp_insn, fp_go_r;
    logic        fpu_off_trap_r, wp_hit_r, priv_mode_r, irq_take_r;
    logic        total_store_order_r, relaxed_order_model_r, order_ld_ld_r;
    logic        order_ld_st_r, order_st_st_r;
    logic [1:0]  memory_model_field_r;
    logic [2:0]  trap_level_r;
    logic [3:0]  avs_byteenable, irq_level_r;
    logic [4:0]  avs_address;
    logic [5:0]  ret_state;
    logic [15:1] irq_level_req, raise;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [63:0] data_va, data_addr_r, cti_target, next_program_counter_r;
    logic [63:0] fetch_addr_r, cur_pc, link_pc_r, ret_pc, ret_pc_r;
    logic [63:0] tpc_wr_data, saved_trap_pc_r, saved_trap_next_pc_r;
    int          n_mismatch, comparisons, k;
    // rows: offset, value written, value read back
    logic [68:0] rows [0:7] = '{{5'h04, 32'h1, 32'h1}, {5'h04, 32'h5, 32'h2},
        {5'h04, 32'h9, 32'h2}, {5'h04, 32'h0, 32'h0}, {5'h08, 32'hf, 32'hf},
        {5'h00, 32'h7f, 32'h3f}, {5'h0c, 32'h1, 32'h1}, {5'h1c, 32'hff, 32'h0}};
    pst_core uut (.*);
    pst_irq_src u_src (.clk, .rst_n, .raise, .clr, .take(irq_take_r),
        .lvl(irq_level_r), .irq_level_req);
    // ------
    // clock, watchdog and shared tasks
    // ------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, far above the length of the whole run
    initial begin
        #2000000;
        n_mismatch++;
        summarize();
    end
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bus cycle; request held until waitrequest low
    task automatic acc(input logic wr, logic [4:0] a, logic [31:0] d);
        int t;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        t = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && t < 50) begin
            @(posedge clk);
            t++;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (t == 50) begin
            n_mismatch++;
            summarize();
        end
    endtask
    // raise levels, check two edges on, then clear
    task automatic irq(input logic [15:1] r, logic t, logic [3:0] l);
        @(posedge clk) raise <= r;
        @(posedge clk) raise <= 15'h0;
        tk(2);
        chk("irq take", t, irq_take_r);
        chk("irq level", l, irq_level_r);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        {avs_read, avs_write, mmu_en, data_req, data_real, data_nontrans} = '0;
        {insn_step, cti_taken, inst_real, link_save, trap_entry} = '0;
        {trap_return, tpc_wr, saved_trap_next_pc_wr, fp_insn, clr, rst_n} = '0;
        {avs_address, avs_writedata, ret_state, raise, data_va} = '0;
        {cti_target, cur_pc, ret_pc, tpc_wr_data} = '0;
        avs_byteenable = 4'hf;
        n_mismatch = 0;
        comparisons = 0;
        tk(16);
        rst_n <= 1'b1;
        tk(1);
        chk("priv", 1, priv_mode_r);
        chk("tl", 0, trap_level_r);
        chk("tso", 1, total_store_order_r);
        $display("reset test done");
        for (k = 0; k < 8; k++) begin
            acc(1'b1, rows[k][68:64], rows[k][63:32]);
            acc(1'b0, rows[k][68:64], 32'h0);
            chk("readback", rows[k][31:0], rd);
        end
        $display("register rows done");
        for (k = 0; k < 4; k++) begin
            acc(1'b1, 5'h00, 32'h10 | k);
            tk(2);
            chk("mm", k, memory_model_field_r);
            chk("tso", k != 2, total_store_order_r);
            chk("rmo", k == 2, relaxed_order_model_r);
            chk("ld order", k != 2, order_ld_ld_r);
            chk("ls order", k != 2, order_ld_st_r);
            chk("st order", k != 2, order_st_st_r);
        end
        $display("memory model test done");
        for (k = 0; k < 4; k++) begin
            acc(1'b1, 5'h00, k[1] ? 32'h14 : 32'h10);
            acc(1'b1, 5'h0c, {31'h0, k[0]});
            @(posedge clk) fp_insn <= 1'b1;
            @(posedge clk) fp_insn <= 1'b0;
            @(posedge clk);
            chk("fp go", k == 3, fp_go_r);
            chk("fp trap", k != 3, fpu_off_trap_r);
        end
        $display("fpu gate test done");
        acc(1'b1, 5'h10, 32'h89abcdef);
        acc(1'b1, 5'h14, 32'h0);
        // k: am, mmu on, real, nontranslating
        for (k = 0; k < 16; k++) begin
            if (k % 8 == 0)
                acc(1'b1, 5'h00, k ? 32'h18 : 32'h10);
            msk = k[3] & k[2] & !k[1] & !k[0];
            @(posedge clk);
            {mmu_en, data_real, data_nontrans} <= k[2:0];
            data_req <= 1'b1;
            data_va <= 64'h01234567_89abcdef;
            @(posedge clk) data_req <= 1'b0;
            @(posedge clk);
            chk("daddr", msk ? 64'h89abcdef : data_va, data_addr_r);
            if (!k[0])
                chk("wp hit", msk, wp_hit_r);
        end
        $display("masking test done");
        acc(1'b1, 5'h00, 32'h10);
        @(posedge clk);
        {insn_step, cti_taken, mmu_en, data_real, data_nontrans} <= 5'b11100;
        cti_target <= 64'hffff0000_00001000;
        @(posedge clk) cti_taken <= 1'b0;
        @(posedge clk) insn_step <= 1'b0;
        @(posedge clk);
        chk("npc", 64'hffff0000_00001004, next_program_counter_r);
        acc(1'b1, 5'h00, 32'h18);
        tk(2);
        chk("fetch", 64'h1004, fetch_addr_r);
        @(posedge clk) {link_save, trap_entry} <= 2'b11;
        cur_pc <= 64'hffff0000_00002000;
        @(posedge clk) {link_save, trap_entry} <= 2'b00;
        @(posedge clk);
        chk("link", 64'h2000, link_pc_r);
        chk("tpc", 64'h2000, saved_trap_pc_r);
        chk("saved_trap_next_pc", 64'h1004, saved_trap_next_pc_r);
        chk("tl up", 1, trap_level_r);
        @(posedge clk) tpc_wr <= 1'b1;
        tpc_wr_data <= 64'hffff0000_00003000;
        @(posedge clk) tpc_wr <= 1'b0;
        acc(1'b1, 5'h04, 32'h2);
        tk(1);
        chk("tl wr", 2, trap_level_r);
        chk("tpc raw", tpc_wr_data, saved_trap_pc_r);
        chk("npc kept", 64'hffff0000_00001004, next_program_counter_r);
        @(posedge clk) trap_return <= 1'b1;
        ret_state <= 6'h08;
        ret_pc <= 64'hffff0000_00004000;
        @(posedge clk) trap_return <= 1'b0;
        @(posedge clk);
        chk("ret npc", ret_pc, next_program_counter_r);
        chk("ret pc", ret_pc, ret_pc_r & {64{ret_valid_r}});
        chk("tl down", 1, trap_level_r);
        acc(1'b1, 5'h00, 32'h10);
        chk("priv", 0, priv_mode_r);
        $display("pc flow test done");
        acc(1'b1, 5'h08, 32'h5);
        irq(15'h4000, 1'b0, 4'hf);
        acc(1'b1, 5'h00, 32'h30);
        irq(15'h0010, 1'b0, 4'h5);
        irq(15'h0020, 1'b1, 4'h6);
        acc(1'b1, 5'h08, 32'hf);
        irq(15'h4000, 1'b0, 4'hf);
        acc(1'b1, 5'h08, 32'he);
        irq(15'h4004, 1'b1, 4'hf);
        $display("interrupt test done");
        @(posedge clk) rst_n <= 1'b0;
        tk(2);
        chk("tl rst", 0, trap_level_r);
        chk("priv rst", 1, priv_mode_r);
        rst_n <= 1'b1;
        tk(2);
        $display("second reset test done");
        summarize();
    end
endmodule
`default_nettype wire
